// [src/hcd_bridge.sv]
// Summary of operation
// [R1] host gives three qualifiers with cycle start
// [R2] locked sequence blocks pci dram access
// [R3] burst indicator on read: line fill
// [R4] burst indicator on write: write-back
// [R5] cacheable/invalidate low on host cycles
// [R6] snoop: invalidate high write, low read
// [R7] host flags management mode while active
// [R8] all check bits driven on writes
// [R9] config selects parity or ecc
// [R10] eight row strobes, one per row
// [R11] eight column strobes
// [R12] row then column on mux address
// [R13] two copies of low burst bits
// [R14] one dram write strobe
// [R15] 64-bit bidirectional dram data bus
// [R16] cycle start marks first clock
// [R17] snoop strobe for pci dram access
// [R18] hash names active low, others high
// [R19] both address copies step together
// [R20] deferred pci request served after lock
`timescale 1ns/1ps
`default_nettype none
module hcd_bridge import hcd_pkg::*; #(
   parameter int BURST = BURST_LEN
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire hcd_host_req_t host_req,
   input wire logic mgmt_mode_active_n,
   input wire hcd_pci_req_t pci_req,
   input wire logic check_mode_select,
   input wire logic [DATA_W-1:0] write_data,
   input wire logic [DATA_W-1:0] dram_data_in,
   input wire logic [CHK_W-1:0] check_bit_in,
   output logic cacheable_invalidate_out,
   output logic snoop_strobe_n,
   output logic pci_grant,
   output logic lock_active,
   output logic mgmt_mode,
   output logic line_fill,
   output logic write_back,
   output var hcd_cycle_t cycle_type,
   output var hcd_dram_strobe_t dram_strobe,
   output logic [MA_HI_W-1:0] dram_mux_address,
   output logic [1:0] burst_addr_copy_a,
   output logic [1:0] burst_addr_copy_b,
   output logic [DATA_W-1:0] dram_data_out,
   output logic dram_data_oe,
   output logic [CHK_W-1:0] check_bit_out,
   output logic check_bit_oe,
   output logic [DATA_W-1:0] read_data,
   output logic check_error
);
   // ----------------------------------------
   // check bit arithmetic
   // ----------------------------------------
   // byte parity, even
   function automatic logic [CHK_W-1:0] byte_par(input logic [DATA_W-1:0] d);
      logic [CHK_W-1:0] p;
      p = '0;
      for (int i = 0; i < CHK_W; i++) begin
         p[i] = ^d[i*8 +: 8];
      end
      return p;
   endfunction
   // simple xor-fold code; a full secded corrector is out of scope here
   function automatic logic [CHK_W-1:0] ecc_gen(input logic [DATA_W-1:0] d);
      logic [CHK_W-1:0] c;
      c = '0;
      for (int i = 0; i < DATA_W; i++) begin
         c = c ^ (i[7:0] + 8'h01);
         if (!d[i]) c = c ^ (i[7:0] + 8'h01);
      end
      return c;
   endfunction
   function automatic logic [CHK_W-1:0] chk_gen(input logic m, input logic [DATA_W-1:0] d);
      return (m == CHK_ECC) ? ecc_gen(d) : byte_par(d); // R9
   endfunction

   // ----------------------------------------
   // state
   // ----------------------------------------
   localparam int BW = $clog2(BURST + 1);
   hcd_state_t state, next_state;
   logic [2:0] tcnt, next_tcnt;
   logic [BW-1:0] beat, next_beat;
   logic cur_write, next_cur_write;
   logic cur_pci, next_cur_pci;
   logic [ROWS-1:0] cur_row, next_cur_row;
   logic [19:0] cur_addr, next_cur_addr;
   logic lock, next_lock;
   logic pend, next_pend;
   logic pend_write, next_pend_write;
   logic [ROWS-1:0] pend_row, next_pend_row;
   logic [19:0] pend_addr, next_pend_addr;
   logic next_ci, next_snoop_n, next_grant, next_lf, next_wb, next_mgmt;
   hcd_cycle_t next_ctype;
   hcd_dram_strobe_t next_strobe;
   logic [MA_HI_W-1:0] next_ma;
   logic [1:0] next_low;
   logic next_oe, next_err;
   logic [DATA_W-1:0] next_dout, next_rdata;
   logic [CHK_W-1:0] next_cbo;
   logic host_start, host_mem;
   logic [1:0] low_bits;

   // host qualifiers are taken only with the cycle start strobe
   assign host_start = !host_req.cycle_start_strobe_n; // R1 R16 R18
   assign host_mem = host_start && host_req.mem_io;
   assign low_bits = cur_addr[1:0] + beat[1:0];

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      next_state = state;
      next_tcnt = tcnt;
      next_beat = beat;
      next_cur_write = cur_write;
      next_cur_pci = cur_pci;
      next_cur_row = cur_row;
      next_cur_addr = cur_addr;
      next_lock = lock;
      next_pend = pend;
      next_pend_write = pend_write;
      next_pend_row = pend_row;
      next_pend_addr = pend_addr;
      next_ci = 1'b0; // R5
      next_snoop_n = 1'b1;
      next_grant = 1'b0;
      next_lf = 1'b0;
      next_wb = 1'b0;
      next_mgmt = !mgmt_mode_active_n; // R7
      next_ctype = cycle_type;
      next_strobe = '{ras_n: '1, cas_n: '1, write_strobe_n: 1'b1};
      next_ma = dram_mux_address;
      next_low = burst_addr_copy_a;
      next_oe = 1'b0;
      next_dout = dram_data_out;
      next_cbo = check_bit_out;
      next_rdata = read_data;
      next_err = 1'b0;
      // lock starts on a strobed locked cycle, ends on negation
      if (host_start && !host_req.bus_lock_n) next_lock = 1'b1; // R2
      else if (host_req.bus_lock_n) next_lock = 1'b0;
      // catch pci request; it waits while locked or busy
      if (pci_req.valid && !pend) begin
         next_pend = 1'b1;
         next_pend_write = pci_req.write;
         next_pend_row = pci_req.row_sel;
         next_pend_addr = pci_req.dram_addr;
      end
      case (state)
         ST_IDLE: begin
            if (host_start) next_ctype = hcd_cycle_t'({host_req.mem_io,
               host_req.data_code, host_req.write_read}); // R1
            if (host_mem) begin
               next_cur_write = host_req.write_read;
               next_cur_pci = 1'b0;
               next_cur_row = host_req.row_sel;
               next_cur_addr = host_req.dram_addr;
               next_lf = !host_req.cache_n && !host_req.write_read; // R3
               next_wb = !host_req.cache_n && host_req.write_read; // R4
               next_beat = '0;
               next_tcnt = 3'(RAS_CYC);
               next_state = ST_ROW;
            end else if (pend && !lock && !(host_start && !host_req.bus_lock_n)) begin
               // deferred request served once the lock drops
               next_pend = 1'b0; // R20 R2
               next_cur_write = pend_write;
               next_cur_pci = 1'b1;
               next_cur_row = pend_row;
               next_cur_addr = pend_addr;
               next_grant = 1'b1;
               next_snoop_n = 1'b0; // R17
               next_ci = pend_write; // R6
               next_state = ST_SNOOP;
            end
         end
         ST_SNOOP: begin
            next_beat = '0;
            next_tcnt = 3'(RAS_CYC);
            next_state = ST_ROW;
         end
         ST_ROW: begin
            // row address on the mux bits, row strobe for the selected row
            next_ma = cur_addr[19:10]; // R12
            next_strobe.ras_n = ~cur_row; // R10
            next_tcnt = tcnt - 3'h1;
            if (tcnt == 3'h1) begin
               next_tcnt = 3'(CAS_CYC);
               next_state = ST_COL;
            end
         end
         ST_COL: begin
            next_strobe.ras_n = ~cur_row;
            next_ma = cur_addr[9:0]; // R12
            next_low = low_bits; // R13 R19
            next_strobe.cas_n = '0; // R11
            next_strobe.write_strobe_n = !cur_write; // R14
            if (cur_write) begin
               next_oe = 1'b1; // R15
               next_dout = write_data;
               next_cbo = chk_gen(check_mode_select, write_data); // R8 R9
            end else begin
               next_rdata = dram_data_in;
               next_err = tcnt == 3'h1 &&
                  chk_gen(check_mode_select, dram_data_in) != check_bit_in; // R9
            end
            next_tcnt = tcnt - 3'h1;
            if (tcnt == 3'h1) begin
               next_tcnt = 3'(CAS_CYC);
               next_beat = beat + BW'(1);
               if (beat == BW'(BURST - 1)) next_state = ST_DONE;
            end
         end
         ST_DONE: begin
            next_state = ST_IDLE;
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         state <= ST_IDLE;
         tcnt <= 3'h0;
         beat <= '0;
         cur_write <= 1'b0;
         cur_pci <= 1'b0;
         cur_row <= '0;
         cur_addr <= '0;
         lock <= 1'b0;
         pend <= 1'b0;
         pend_write <= 1'b0;
         pend_row <= '0;
         pend_addr <= '0;
         cacheable_invalidate_out <= 1'b0;
         snoop_strobe_n <= 1'b1;
         pci_grant <= 1'b0;
         line_fill <= 1'b0;
         write_back <= 1'b0;
         mgmt_mode <= 1'b0;
         cycle_type <= HCD_INTA;
         dram_strobe <= '{ras_n: '1, cas_n: '1, write_strobe_n: 1'b1};
         dram_mux_address <= '0;
         burst_addr_copy_a <= 2'h0;
         burst_addr_copy_b <= 2'h0;
         dram_data_out <= '0;
         dram_data_oe <= 1'b0;
         check_bit_out <= '0;
         check_bit_oe <= 1'b0;
         read_data <= '0;
         check_error <= 1'b0;
      end else begin
         state <= next_state;
         tcnt <= next_tcnt;
         beat <= next_beat;
         cur_write <= next_cur_write;
         cur_pci <= next_cur_pci;
         cur_row <= next_cur_row;
         cur_addr <= next_cur_addr;
         lock <= next_lock;
         pend <= next_pend;
         pend_write <= next_pend_write;
         pend_row <= next_pend_row;
         pend_addr <= next_pend_addr;
         cacheable_invalidate_out <= next_ci;
         snoop_strobe_n <= next_snoop_n;
         pci_grant <= next_grant;
         line_fill <= next_lf;
         write_back <= next_wb;
         mgmt_mode <= next_mgmt;
         cycle_type <= next_ctype;
         dram_strobe <= next_strobe;
         dram_mux_address <= next_ma;
         burst_addr_copy_a <= next_low; // R13
         burst_addr_copy_b <= next_low; // R19
         dram_data_out <= next_dout;
         dram_data_oe <= next_oe;
         check_bit_out <= next_cbo;
         check_bit_oe <= next_oe; // R8
         read_data <= next_rdata;
         check_error <= next_err;
      end
   end
   assign lock_active = lock;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   chk_lock_blocks_pci: assert property (@(posedge clk_sys) disable iff (reset) // R2
      lock |=> !pci_grant) else $error("pci granted while locked");
   chk_copies_equal: assert property (@(posedge clk_sys) disable iff (reset) // R19
      burst_addr_copy_a == burst_addr_copy_b) else $error("address copies differ");
   // equality alone holds by wiring; this one guards the actual step per beat
   chk_copy_step: assert property (@(posedge clk_sys) disable iff (reset) // R19
      (state == ST_COL && tcnt == 3'h1 && beat != BW'(BURST - 1))
      |=> ##1 burst_addr_copy_a == 2'($past(burst_addr_copy_a) + 2'h1))
      else $error("address copy did not step");
   chk_check_bits_drive: assert property (@(posedge clk_sys) disable iff (reset) // R8
      !dram_strobe.write_strobe_n |-> check_bit_oe && dram_data_oe)
      else $error("check bits not driven on write");
   chk_snoop_inv: assert property (@(posedge clk_sys) disable iff (reset) // R6
      !snoop_strobe_n |-> cacheable_invalidate_out == cur_write)
      else $error("invalidate level wrong on snoop");
   chk_host_ci_low: assert property (@(posedge clk_sys) disable iff (reset) // R5
      snoop_strobe_n |-> !cacheable_invalidate_out) else $error("cacheable not low");
   chk_snoop_grant: assert property (@(posedge clk_sys) disable iff (reset) // R17
      pci_grant |-> !snoop_strobe_n ##1 state == ST_ROW) else $error("snoop missing");
   chk_line_fill: assert property (@(posedge clk_sys) disable iff (reset) // R3
      (state == ST_IDLE && host_mem && !host_req.cache_n && !host_req.write_read)
      |=> line_fill && !write_back) else $error("line fill not flagged");
   chk_write_back: assert property (@(posedge clk_sys) disable iff (reset) // R4
      (state == ST_IDLE && host_mem && !host_req.cache_n && host_req.write_read)
      |=> write_back && !line_fill) else $error("write-back not flagged");
   chk_row_then_col: assert property (@(posedge clk_sys) disable iff (reset) // R12
      (state == ST_ROW && tcnt == 3'h1) |=> ##1 dram_mux_address == cur_addr[9:0])
      else $error("column address late");
   chk_cas_with_ras: assert property (@(posedge clk_sys) disable iff (reset) // R11
      dram_strobe.cas_n != '1 |-> dram_strobe.ras_n != '1) else $error("cas without ras");
   chk_cycle_decode: assert property (@(posedge clk_sys) disable iff (reset) // R1
      (state == ST_IDLE && host_start) |=> cycle_type == $past({host_req.mem_io,
      host_req.data_code, host_req.write_read})) else $error("cycle type wrong");
endmodule // hcd_bridge
`default_nettype wire

// [include/hcd_pkg.sv]
// ----------------------------------------
// shared types and constants
// ----------------------------------------
package hcd_pkg;
   localparam int DATA_W = 64;
   localparam int CHK_W = 8;
   localparam int ROWS = 8;
   localparam int MA_HI_W = 10;
   localparam int BURST_LEN = 4;
   // dram phase timing in cycles (own choice, 50 ns clock)
   localparam int RAS_CYC = 2;
   localparam int CAS_CYC = 2;
   // check mode encoding
   localparam logic CHK_PARITY = 1'h0;
   localparam logic CHK_ECC = 1'h1;
   // cycle types from the three qualifiers {mem_io, data_code, write_read}
   typedef enum logic [2:0] {
      HCD_INTA = 3'h0, HCD_SPECIAL = 3'h1, HCD_IO_RD = 3'h2, HCD_IO_WR = 3'h3,
      HCD_CODE_RD = 3'h4, HCD_RSVD = 3'h5, HCD_MEM_RD = 3'h6, HCD_MEM_WR = 3'h7
   } hcd_cycle_t;
   // host request carrier (polarity as on the pins)
   typedef struct packed {
      logic cycle_start_strobe_n;
      logic mem_io;
      logic data_code;
      logic write_read;
      logic bus_lock_n;
      logic cache_n;
      logic [ROWS-1:0] row_sel;
      logic [19:0] dram_addr;
   } hcd_host_req_t;
   // pci master request carrier
   typedef struct packed {
      logic valid;
      logic write;
      logic [ROWS-1:0] row_sel;
      logic [19:0] dram_addr;
   } hcd_pci_req_t;
   // dram strobe group, all active low
   typedef struct packed {
      logic [ROWS-1:0] ras_n;
      logic [ROWS-1:0] cas_n;
      logic write_strobe_n;
   } hcd_dram_strobe_t;
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0, ST_ROW = 3'h1, ST_COL = 3'h3, ST_DONE = 3'h2, ST_SNOOP = 3'h6
   } hcd_state_t;
endpackage

// [dv/hcd_dram_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// dram array model, four qwords of one row
// ----------------------------------------
module hcd_dram_model import hcd_pkg::*; (
   input wire logic clk_sys,
   input wire hcd_dram_strobe_t dram_strobe,
   input wire logic [1:0] burst_addr_copy_a,
   input wire logic [DATA_W-1:0] dram_data_out,
   input wire logic [CHK_W-1:0] check_bit_out,
   input wire logic inject_err,
   output logic [DATA_W-1:0] dram_data_in,
   output logic [CHK_W-1:0] check_bit_in
);
   logic [DATA_W-1:0] mem [4];
   logic [CHK_W-1:0] chk [4];
   logic [DATA_W-1:0] last_d = '0;
   logic [CHK_W-1:0] last_c = '0;
   logic rd;
   logic wr;
   // strobes are active low; row choice is ignored, one row is enough here
   assign rd = (dram_strobe.cas_n != '1) && dram_strobe.write_strobe_n;
   assign wr = (dram_strobe.cas_n != '1) && !dram_strobe.write_strobe_n;
   // data and all eight check bits land together on each write beat
   always @(posedge clk_sys) begin
      if (wr) begin
         mem[burst_addr_copy_a] <= dram_data_out;
         chk[burst_addr_copy_a] <= check_bit_out;
      end
      last_d <= dram_data_in;
      last_c <= check_bit_in;
   end
   // a released bus shows the inverse of the last value, so a stale copy returns every other cycle
   assign dram_data_in = rd ? mem[burst_addr_copy_a] : ~last_d;
   assign check_bit_in = rd ? (chk[burst_addr_copy_a] ^ {7'h0, inject_err}) : ~last_c;
endmodule // hcd_dram_model
`default_nettype wire

// [dv/host_cycle_and_dram_pin_control_test.sv]
`timescale 1ns/1ps
`default_nettype none
module host_cycle_and_dram_pin_control_test import hcd_pkg::*;;
   logic clk_sys, reset, mgmt_mode_active_n, check_mode_select, inject_err;
   hcd_host_req_t host_req;
   hcd_pci_req_t pci_req;
   logic [DATA_W-1:0] write_data, dram_data_in, dram_data_out, read_data;
   logic [CHK_W-1:0] check_bit_in, check_bit_out;
   logic cacheable_invalidate_out, snoop_strobe_n, pci_grant, lock_active, mgmt_mode;
   logic line_fill, write_back, dram_data_oe, check_bit_oe, check_error;
   hcd_cycle_t cycle_type;
   hcd_dram_strobe_t dram_strobe;
   logic [MA_HI_W-1:0] dram_mux_address;
   logic [1:0] burst_addr_copy_a, burst_addr_copy_b;
   int err_total = 0;
   int num_checks = 0;
   hcd_bridge uut (.clk_sys(clk_sys), .reset(reset), .host_req(host_req),
      .mgmt_mode_active_n(mgmt_mode_active_n), .pci_req(pci_req),
      .check_mode_select(check_mode_select), .write_data(write_data),
      .dram_data_in(dram_data_in), .check_bit_in(check_bit_in),
      .cacheable_invalidate_out(cacheable_invalidate_out), .snoop_strobe_n(snoop_strobe_n),
      .pci_grant(pci_grant), .lock_active(lock_active), .mgmt_mode(mgmt_mode),
      .line_fill(line_fill), .write_back(write_back), .cycle_type(cycle_type),
      .dram_strobe(dram_strobe), .dram_mux_address(dram_mux_address),
      .burst_addr_copy_a(burst_addr_copy_a), .burst_addr_copy_b(burst_addr_copy_b),
      .dram_data_out(dram_data_out), .dram_data_oe(dram_data_oe),
      .check_bit_out(check_bit_out), .check_bit_oe(check_bit_oe),
      .read_data(read_data), .check_error(check_error));
   hcd_dram_model dram (.clk_sys(clk_sys), .dram_strobe(dram_strobe),
      .burst_addr_copy_a(burst_addr_copy_a), .dram_data_out(dram_data_out),
      .check_bit_out(check_bit_out), .inject_err(inject_err),
      .dram_data_in(dram_data_in), .check_bit_in(check_bit_in));
   // ----------------------------------------
   // clock, compare and closing report
   // ----------------------------------------
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // ----------------------------------------
   // request driver and transfer watcher
   // ----------------------------------------
   // a gap of two cycles first, so a start never lands in the done cycle
   task automatic req(input bit pci, input logic [2:0] code, input bit burst,
      input logic [7:0] rs, input logic [19:0] a);
      repeat (2) @(negedge clk_sys);
      if (pci) pci_req = '{1'b1, code[0], rs, a};
      else host_req = '{1'b0, code[2], code[1], code[0], host_req.bus_lock_n, !burst, rs, a};
      @(negedge clk_sys);
      pci_req.valid = 1'b0;
      host_req.cycle_start_strobe_n = 1'b1;
   endtask
   task automatic watch(input bit pci, input logic [2:0] code, input bit burst,
      input logic [7:0] rs, input logic [19:0] a);
      int n;
      int sn;
      bit lf, wb, er, up;
      logic [1:0] q[$];
      sn = 0;
      lf = 0;
      wb = 0;
      er = 0;
      up = 0;
      for (n = 0; n < 100 && !(up && dram_strobe.ras_n == '1); n++) begin
         lf |= line_fill;
         wb |= write_back;
         er |= check_error;
         if (!snoop_strobe_n) begin
            sn++;
            chk("invalidate", cacheable_invalidate_out, code[0]);
         end else if (!pci) chk("cacheable", cacheable_invalidate_out, 0);
         if (dram_strobe.ras_n != '1 && !up) begin
            up = 1;
            chk("row strobe", dram_strobe.ras_n, 8'(~rs));
            chk("row addr", dram_mux_address, a[19:10]);
         end
         if (dram_strobe.cas_n != '1) begin
            chk("copies", burst_addr_copy_b, burst_addr_copy_a);
            if (q.size() == 0 || q[$] !== burst_addr_copy_a) q.push_back(burst_addr_copy_a);
            chk("ras held", dram_strobe.ras_n, 8'(~rs));
            chk("write strobe", dram_strobe.write_strobe_n, !code[0]);
            chk("data oe", dram_data_oe, code[0]);
            chk("check oe", check_bit_oe, code[0]);
            if (code[0]) chk("write data", dram_data_out, write_data);
         end
         @(negedge clk_sys);
      end
      if (n >= 100) begin
         err_total++;
         summarize();
      end
      chk("line fill", lf, !pci && burst && !code[0]);
      chk("write back", wb, !pci && burst && code[0]);
      chk("snoops", sn, pci);
      if (!pci) chk("type", cycle_type, code);
      if (burst) chk("beats", q.size(), BURST_LEN);
      for (int k = 0; k < BURST_LEN && burst; k++) chk("step", q[k], 2'(a[1:0] + k));
      if (!code[0]) chk("check error", er, inject_err);
      if (!code[0] && !inject_err) chk("read data", read_data, write_data);
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   // write then read back a line, then read with one check bit flipped
   task automatic t_burst(input logic mode, input logic [63:0] d);
      check_mode_select = mode;
      write_data = d;
      req(0, 3'h7, 1, 8'h80, 20'hA5C02);
      watch(0, 3'h7, 1, 8'h80, 20'hA5C02);
      req(0, 3'h6, 1, 8'h80, 20'hA5C01);
      watch(0, 3'h6, 1, 8'h80, 20'hA5C01);
      inject_err = 1'b1;
      req(0, 3'h6, 0, 8'h80, 20'hA5C03);
      watch(0, 3'h6, 0, 8'h80, 20'hA5C03);
      inject_err = 1'b0;
      $display("done burst mode %0d", mode);
   endtask
   // every qualifier code; non-memory ones only change the decoded type
   task automatic t_types;
      for (int c = 0; c < 8; c++) begin
         req(0, 3'(c), 0, 8'h01 << c, 20'h3F002);
         if (c >= 4) watch(0, 3'(c), 0, 8'h01 << c, 20'h3F002);
         for (int k = 0; k < 3 && c < 4; k++) begin
            chk("no row", dram_strobe.ras_n, 8'hFF);
            @(negedge clk_sys);
         end
         if (c < 4) chk("type", cycle_type, 3'(c));
      end
      $display("done types");
   endtask
   task automatic t_snoop;
      req(1, 3'h1, 0, 8'h02, 20'h12343);
      watch(1, 3'h1, 0, 8'h02, 20'h12343);
      req(1, 3'h0, 0, 8'h02, 20'h12343);
      watch(1, 3'h0, 0, 8'h02, 20'h12343);
      $display("done snoop");
   endtask
   // a pci request raised under lock must wait for the lock to drop
   task automatic t_lock;
      host_req.bus_lock_n = 1'b0;
      req(0, 3'h6, 0, 8'h08, 20'h00402);
      watch(0, 3'h6, 0, 8'h08, 20'h00402);
      chk("lock", lock_active, 1);
      req(1, 3'h1, 0, 8'h10, 20'h00402);
      repeat (20) begin
         chk("no snoop", snoop_strobe_n, 1);
         chk("no row", dram_strobe.ras_n, 8'hFF);
         @(negedge clk_sys);
      end
      host_req.bus_lock_n = 1'b1;
      watch(1, 3'h1, 0, 8'h10, 20'h00402);
      chk("unlock", lock_active, 0);
      $display("done lock");
   endtask
   task automatic t_mgmt;
      mgmt_mode_active_n = 1'b0;
      repeat (2) @(negedge clk_sys);
      chk("mgmt on", mgmt_mode, 1);
      mgmt_mode_active_n = 1'b1;
      repeat (2) @(negedge clk_sys);
      chk("mgmt off", mgmt_mode, 0);
      $display("done mgmt");
   endtask
   // main sequence; inputs change only at falling edges
   initial begin
      reset = 1'b1;
      host_req = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 8'h00, 20'h00000};
      pci_req = '0;
      mgmt_mode_active_n = 1'b1;
      check_mode_select = CHK_PARITY;
      inject_err = 1'b0;
      write_data = 64'h0;
      repeat (6) @(negedge clk_sys);
      reset = 1'b0;
      chk("strobes idle", dram_strobe, {17{1'b1}});
      chk("snoop idle", snoop_strobe_n, 1);
      t_burst(CHK_PARITY, 64'h0123_4567_89AB_CDEF);
      t_burst(CHK_ECC, 64'hF0E1_D2C3_B4A5_9687);
      t_types();
      t_snoop();
      t_lock();
      t_mgmt();
      summarize();
   end
endmodule // host_cycle_and_dram_pin_control_test
`default_nettype wire
